// File: pmcc_params.svh
// Constants for the power mode and reference clock configuration block
//------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------
// Functional notes
// - Power-down: synth off, supply filter stays on
// - Deep sleep: every synth block off, filter too
// - Bias reference low power in sleep or power-down
// - Synth compares phase at 500 kHz reference
// - Divide reference by 72 (36M) or 52 (26M)
// - Style bit one: open-drain, pull low only
// - Style bit zero: push-pull, drive both levels
// - Output pin shows the level bit value
// - Output port active and responsive in power-down
// - Output port holds state across power transitions
// - Three comparators resolve four levels, open is top
// - Levels map to 36/26 MHz, diff/single-ended
// - Decoded pin config applied once enable high
// - Override low: config from decoded pin
// - Override high: config from register bits
// - Override bit resets to zero
// - Pin decoder works unchanged in power-down
// - Pin decoder disabled in deep sleep
// - Exactly one clock output buffer enabled
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH

//------------------------------------------------------------------------
// Register indices and byte addresses
//------------------------------------------------------------------------
`define PMCC_IDX_MODE       8'h00
`define PMCC_IDX_REF        8'h01
`define PMCC_IDX_PAD        8'h05
`define PMCC_IDX_PORT       8'h06
`define PMCC_IDX_STATUS     8'h07
`define PMCC_ADDR_MODE      (`PMCC_IDX_MODE   << 2)
`define PMCC_ADDR_REF       (`PMCC_IDX_REF    << 2)
`define PMCC_ADDR_PAD       (`PMCC_IDX_PAD    << 2)
`define PMCC_ADDR_PORT      (`PMCC_IDX_PORT   << 2)
`define PMCC_ADDR_STATUS    (`PMCC_IDX_STATUS << 2)

//------------------------------------------------------------------------
// Field positions
//------------------------------------------------------------------------
`define PMCC_BIT_PDR        0
`define PMCC_BIT_REFSEL     0
`define PMCC_BIT_OVR        0
`define PMCC_BIT_BUFSEL     1
`define PMCC_BIT_STYLE      0
`define PMCC_BIT_LEVEL      1

//------------------------------------------------------------------------
// Reset values
//------------------------------------------------------------------------
`define PMCC_RST_BIT        1'b0
`define PMCC_RST_WORD       32'h0000_0000
`define PMCC_RST_LEVEL      2'h0

//------------------------------------------------------------------------
// Reference divider ratios
//------------------------------------------------------------------------
`define PMCC_DIV_36M        7'h48
`define PMCC_DIV_26M        7'h34
`define PMCC_CNT_ZERO       7'h0
`define PMCC_CNT_ONE        7'h1

`endif

// File: pmcc_pkg.sv
// Types shared by the power mode and clock configuration block
package pmcc_pkg;

    // Power state, Gray coded along sleep -> normal -> power-down
    typedef enum logic [1:0] {
        PMCC_ST_SLEEP  = 2'b00,
        PMCC_ST_NORMAL = 2'b01,
        PMCC_ST_PDOWN  = 2'b11
    } pmcc_pwr_t;

    // Decoded multi-level pin level
    typedef logic [1:0] pmcc_level_t;

endpackage

// File: pmcc_sync2.sv
// Two-stage level synchroniser
`timescale 1ns/10ps
`include "pmcc_params.svh"
module pmcc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// File: pmcc_refdiv.sv
// Reference divider producing the phase comparison tick
`timescale 1ns/10ps
`include "pmcc_params.svh"
module pmcc_refdiv (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // Control
    input  wire logic run_i,
    input  wire logic sel_26m_i,
    // Tick out
    output logic      tick_o
);

    logic [6:0] cnt_q;
    logic       sel_q;
    wire  [6:0] ratio    = sel_26m_i ? `PMCC_DIV_26M : `PMCC_DIV_36M;
    wire  [6:0] term     = ratio - `PMCC_CNT_ONE;
    wire        restart  = !run_i || (sel_q != sel_26m_i);
    wire        at_term  = (cnt_q == term);

    // Counter restarts on a ratio change so no short period escapes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q  <= `PMCC_CNT_ZERO;
            sel_q  <= `PMCC_RST_BIT;
            tick_o <= `PMCC_RST_BIT;
        end else begin
            sel_q  <= sel_26m_i;
            cnt_q  <= (restart || at_term) ? `PMCC_CNT_ZERO
                                           : cnt_q + `PMCC_CNT_ONE;
            tick_o <= !restart && at_term;
        end
    end

    tick_period_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (run_i && sel_q == sel_26m_i && cnt_q == term) |=> tick_o)
        else $error("reference tick missed at terminal count");

endmodule

// File: pmcc_top.sv
// Power mode, reference clock configuration and logic output port
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "pmcc_params.svh"
module pmcc_top
    import pmcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device pins
    input  wire logic        enable_i,
    input  wire logic [2:0]  level_cmp_i,
    // Synthesizer and bias controls
    output logic             synth_core_en_o,
    output logic             filter_supply_rail_en_o,
    output logic             bias_reference_module_lp_o,
    output logic             multilevel_pin_decoder_en_o,
    output logic             pfd_ref_tick_o,
    // Reference configuration
    output logic             ref_is_26m_o,
    output logic             clk_buf_diff_en_o,
    output logic             clk_buf_se_en_o,
    // Logic output pin
    output logic             logic_output_pin_o,
    output logic             logic_output_pin_oe_n_o
);

    //--------------------------------------------------------------------
    // Software registers
    //--------------------------------------------------------------------
    logic        power_down_request_q;
    logic        ref_freq_select_q;
    logic        pin_config_override_q;
    logic        clock_buffer_select_q;
    logic        port_drive_style_q;
    logic        port_output_level_q;

    //--------------------------------------------------------------------
    // Internal state
    //--------------------------------------------------------------------
    pmcc_pwr_t   pwr_q;
    pmcc_pwr_t   pwr_d;
    pmcc_level_t mlp_level_q;
    logic [2:0]  cmp_sync;
    logic        ref26_q;
    logic        buf_se_q;

    //--------------------------------------------------------------------
    // APB decode
    //--------------------------------------------------------------------
    wire access    = psel && penable;
    wire done      = access && pready;
    wire hit_mode  = (paddr == `PMCC_ADDR_MODE);
    wire hit_ref   = (paddr == `PMCC_ADDR_REF);
    wire hit_pad   = (paddr == `PMCC_ADDR_PAD);
    wire hit_port  = (paddr == `PMCC_ADDR_PORT);
    wire hit_stat  = (paddr == `PMCC_ADDR_STATUS);
    wire mapped    = hit_mode || hit_ref || hit_pad || hit_port || hit_stat;
    wire wr_done   = done && pwrite;
    wire wr_mode   = wr_done && hit_mode;
    wire wr_ref    = wr_done && hit_ref;
    wire wr_pad    = wr_done && hit_pad;
    wire wr_port   = wr_done && hit_port;

    // Read mux; narrow fields sit in the low bits, the rest read zero
    wire [31:0] rd_mode = {31'h0, power_down_request_q};
    wire [31:0] rd_ref  = {31'h0, ref_freq_select_q};
    wire [31:0] rd_pad  = {30'h0, clock_buffer_select_q,
                           pin_config_override_q};
    wire [31:0] rd_port = {30'h0, port_output_level_q, port_drive_style_q};
    wire [31:0] rd_stat = {26'h0, pwr_q, buf_se_q, ref26_q, mlp_level_q};
    wire [31:0] rd_data = hit_mode ? rd_mode :
                          hit_ref  ? rd_ref  :
                          hit_pad  ? rd_pad  :
                          hit_port ? rd_port :
                          hit_stat ? rd_stat : `PMCC_RST_WORD;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready  <= `PMCC_RST_BIT;
            pslverr <= `PMCC_RST_BIT;
            prdata  <= `PMCC_RST_WORD;
        end else begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !mapped;
            prdata  <= (access && !pready && !pwrite) ? rd_data
                                                      : `PMCC_RST_WORD;
        end
    end

    //--------------------------------------------------------------------
    // Register writes
    //--------------------------------------------------------------------
    // Override resets low so the pin rules after power-on
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            power_down_request_q  <= `PMCC_RST_BIT;
            ref_freq_select_q     <= `PMCC_RST_BIT;
            pin_config_override_q <= `PMCC_RST_BIT;
            clock_buffer_select_q <= `PMCC_RST_BIT;
            port_drive_style_q    <= `PMCC_RST_BIT;
            port_output_level_q   <= `PMCC_RST_BIT;
        end else begin
            if (wr_mode)
                power_down_request_q <= pwdata[`PMCC_BIT_PDR];
            if (wr_ref)
                ref_freq_select_q <= pwdata[`PMCC_BIT_REFSEL];
            if (wr_pad) begin
                pin_config_override_q <= pwdata[`PMCC_BIT_OVR];
                clock_buffer_select_q <= pwdata[`PMCC_BIT_BUFSEL];
            end
            if (wr_port) begin
                port_drive_style_q  <= pwdata[`PMCC_BIT_STYLE];
                port_output_level_q <= pwdata[`PMCC_BIT_LEVEL];
            end
        end
    end

    //--------------------------------------------------------------------
    // Power state
    //--------------------------------------------------------------------
    // Enable pin dominates; the request bit only matters while enabled
    always_comb begin
        case ({enable_i, power_down_request_q})
            2'b10:   pwr_d = PMCC_ST_NORMAL;
            2'b11:   pwr_d = PMCC_ST_PDOWN;
            default: pwr_d = PMCC_ST_SLEEP;
        endcase
    end

    wire nxt_normal = (pwr_d == PMCC_ST_NORMAL);
    wire nxt_sleep  = (pwr_d == PMCC_ST_SLEEP);

    // Outputs follow the next state so they line up with pwr_q
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwr_q                       <= PMCC_ST_SLEEP;
            synth_core_en_o             <= `PMCC_RST_BIT;
            filter_supply_rail_en_o     <= `PMCC_RST_BIT;
            bias_reference_module_lp_o  <= !`PMCC_RST_BIT;
            multilevel_pin_decoder_en_o <= `PMCC_RST_BIT;
        end else begin
            pwr_q                       <= pwr_d;
            synth_core_en_o             <= nxt_normal;
            filter_supply_rail_en_o     <= !nxt_sleep;
            bias_reference_module_lp_o  <= !nxt_normal;
            multilevel_pin_decoder_en_o <= !nxt_sleep;
        end
    end

    //--------------------------------------------------------------------
    // Multi-level pin decoder
    //--------------------------------------------------------------------
    // Comparators are not timed to our clock, so resynchronise them
    pmcc_sync2 #(
        .W (3)
    ) u_cmp_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (level_cmp_i),
        .sync_o    (cmp_sync)
    );

    // Thermometer to level; the pull-up makes an open pin level 3
    wire pmcc_level_t level_dec = cmp_sync[2] ? 2'h3 :
                                  cmp_sync[1] ? 2'h2 :
                                  cmp_sync[0] ? 2'h1 : 2'h0;

    // Level is taken only while enabled, held in deep sleep
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mlp_level_q <= `PMCC_RST_LEVEL;
        end else if (enable_i) begin
            mlp_level_q <= level_dec;
        end
    end

    //--------------------------------------------------------------------
    // Effective configuration
    //--------------------------------------------------------------------
    // Level bit 1 selects 26 MHz, bit 0 selects single-ended
    wire pin_ref26  = mlp_level_q[1];
    wire pin_se     = mlp_level_q[0];
    wire eff_ref26  = pin_config_override_q ? ref_freq_select_q
                                            : pin_ref26;
    wire eff_se     = pin_config_override_q ? clock_buffer_select_q
                                            : pin_se;

    // Buffers load complements of eff_se, so never both on
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref26_q           <= `PMCC_RST_BIT;
            buf_se_q          <= `PMCC_RST_BIT;
            ref_is_26m_o      <= `PMCC_RST_BIT;
            clk_buf_diff_en_o <= !`PMCC_RST_BIT;
            clk_buf_se_en_o   <= `PMCC_RST_BIT;
        end else begin
            ref26_q           <= eff_ref26;
            buf_se_q          <= eff_se;
            ref_is_26m_o      <= eff_ref26;
            clk_buf_diff_en_o <= !eff_se;
            clk_buf_se_en_o   <= eff_se;
        end
    end

    //--------------------------------------------------------------------
    // Phase comparison reference
    //--------------------------------------------------------------------
    // Divider stops whenever the synthesizer core is off
    pmcc_refdiv u_refdiv (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (synth_core_en_o),
        .sel_26m_i (ref26_q),
        .tick_o    (pfd_ref_tick_o)
    );

    //--------------------------------------------------------------------
    // Logic output port
    //--------------------------------------------------------------------
    // Independent of power state, so it keeps its value in power-down
    wire lop_oe_n_d = port_drive_style_q && port_output_level_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            logic_output_pin_o      <= `PMCC_RST_BIT;
            logic_output_pin_oe_n_o <= `PMCC_RST_BIT;
        end else begin
            logic_output_pin_o      <= port_output_level_q;
            logic_output_pin_oe_n_o <= lop_oe_n_d;
        end
    end

    //--------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------
    pd_synth_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pwr_q == PMCC_ST_PDOWN |-> !synth_core_en_o
                                   && filter_supply_rail_en_o)
        else $error("power-down left synth on or filter off");

    sleep_all_off_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !enable_i |=> !synth_core_en_o && !filter_supply_rail_en_o
                      && !multilevel_pin_decoder_en_o)
        else $error("deep sleep left a block enabled");

    bias_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!enable_i || power_down_request_q)
        |=> bias_reference_module_lp_o)
        else $error("bias reference not in low power");

    buf_onehot_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_buf_diff_en_o != clk_buf_se_en_o)
        else $error("clock buffers not exactly one enabled");

    lop_open_drain_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        port_drive_style_q |=> logic_output_pin_oe_n_o
                               == $past(port_output_level_q))
        else $error("open-drain port drives high");

    lop_push_pull_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !port_drive_style_q |=> !logic_output_pin_oe_n_o
            && logic_output_pin_o == $past(port_output_level_q))
        else $error("push-pull port not driving its level");

    override_cfg_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        pin_config_override_q |=> ref_is_26m_o == $past(ref_freq_select_q)
            && clk_buf_se_en_o == $past(clock_buffer_select_q))
        else $error("override bits not applied");

    pin_cfg_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !pin_config_override_q |=> ref_is_26m_o == $past(mlp_level_q[1])
            && clk_buf_se_en_o == $past(mlp_level_q[0]))
        else $error("pin level not applied");

    decoder_hold_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !enable_i |=> $stable(mlp_level_q))
        else $error("decoder level changed in deep sleep");

endmodule

// File: pmcc_board_model.sv
// Board-side model of the configuration strap and the logic output load
`timescale 1ns/10ps
module pmcc_board_model (
    // Configuration strap
    input  wire logic [1:0] level_i,
    input  wire logic       open_i,
    output logic      [2:0] cmp_o,
    // Logic output pin load
    input  wire logic       pin_i,
    input  wire logic       pin_oe_n_i,
    output logic            pin_wire_o
);
    // Thermometer comparators; an open strap floats to the top level
    assign cmp_o = open_i ? 3'h7 : (3'h7 >> (2'h3 - level_i));
    // Board pull-up lifts the line whenever the driver lets go
    assign pin_wire_o = pin_oe_n_i ? 1'b1 : pin_i;
endmodule

// File: tb_pmcc_top.sv
// Self-checking bench for the power mode and clock configuration block
`timescale 1ns/10ps
`include "pmcc_params.svh"
module tb_pmcc_top import pmcc_pkg::*; ;
    //--------------------------------------------------------------------
    // Signals
    //--------------------------------------------------------------------
    logic        clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        enable_i, syn_en, flt_en, lp, dec_en, tick, is26, bdiff;
    logic        bse, pin_o, pin_oe_n, pin_wire, pin_open, err;
    logic [2:0]  level_cmp_i;
    logic [1:0]  pin_lvl;
    int          n_errors, checks;
    int          cyc = 0;

    pmcc_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enable_i(enable_i), .level_cmp_i(level_cmp_i),
        .synth_core_en_o(syn_en), .filter_supply_rail_en_o(flt_en),
        .bias_reference_module_lp_o(lp),
        .multilevel_pin_decoder_en_o(dec_en), .pfd_ref_tick_o(tick),
        .ref_is_26m_o(is26), .clk_buf_diff_en_o(bdiff),
        .clk_buf_se_en_o(bse), .logic_output_pin_o(pin_o),
        .logic_output_pin_oe_n_o(pin_oe_n));

    pmcc_board_model u_board (.level_i(pin_lvl), .open_i(pin_open),
        .cmp_o(level_cmp_i), .pin_i(pin_o), .pin_oe_n_i(pin_oe_n),
        .pin_wire_o(pin_wire));

    //--------------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One APB transfer; pready is read at the edge, before it updates
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        // No wait is assumed; only the run timeout ends a hang here
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------
    task automatic t_reset();
        chk(lp, 1'b1);
        chk({syn_en, flt_en, dec_en}, 3'h0);
        chk({bdiff, bse}, 2'h2);
        chk({pin_o, pin_oe_n}, 2'h0);
        apb(1'b0, `PMCC_ADDR_PAD, 32'h0);
        chk(rd, `PMCC_RST_WORD);
        // Unmapped place: error flag, write dropped, read zero
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk(err, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        $display("test reset done");
    endtask

    task automatic t_power();
        logic en;
        logic pd;
        for (int i = 0; i < 3; i++) begin
            en = (i != 2);
            pd = (i == 1);
            enable_i <= en;
            apb(1'b1, `PMCC_ADDR_MODE, {31'h0, pd});
            w(2);
            chk(syn_en, en & !pd);
            chk(flt_en, en);
            chk(lp, !en | pd);
            chk(dec_en, en);
            apb(1'b0, `PMCC_ADDR_STATUS, 32'h0);
            chk(rd[5:4], en ? (pd ? PMCC_ST_PDOWN : PMCC_ST_NORMAL)
                            : PMCC_ST_SLEEP);
        end
        $display("test power done");
    endtask

    task automatic t_pins();
        logic [1:0] e;
        enable_i <= 1'b1;
        apb(1'b1, `PMCC_ADDR_MODE, 32'h0);
        apb(1'b1, `PMCC_ADDR_PAD, 32'h0);
        for (int lv = 0; lv < 5; lv++) begin
            e = (lv == 4) ? 2'h3 : lv[1:0];
            pin_lvl <= lv[1:0];
            pin_open <= (lv == 4);
            w(6);
            chk({is26, bse, bdiff}, {e[1], e[0], !e[0]});
            apb(1'b0, `PMCC_ADDR_STATUS, 32'h0);
            chk(rd[3:0], {e[0], e[1], e});
        end
        // Decoder keeps working in power-down
        apb(1'b1, `PMCC_ADDR_MODE, 32'h1);
        pin_open <= 1'b0;
        pin_lvl <= 2'h1;
        w(6);
        chk({is26, bse}, 2'h1);
        // Sleep holds the old choice; waking applies the new strap
        enable_i <= 1'b0;
        pin_lvl <= 2'h2;
        w(6);
        apb(1'b0, `PMCC_ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'h1);
        enable_i <= 1'b1;
        apb(1'b1, `PMCC_ADDR_MODE, 32'h0);
        w(6);
        chk({is26, bse, bdiff}, 3'h5);
        $display("test pins done");
    endtask

    task automatic t_override();
        pin_lvl <= 2'h0;
        w(6);
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, `PMCC_ADDR_REF, {31'h0, v[0]});
            apb(1'b1, `PMCC_ADDR_PAD, {30'h0, v[1], 1'b1});
            w(2);
            chk({is26, bse, bdiff}, {v[0], v[1], !v[1]});
        end
        apb(1'b1, `PMCC_ADDR_PAD, 32'h0);
        w(2);
        chk({is26, bse, bdiff}, 3'h1);
        $display("test override done");
    endtask

    task automatic t_tick();
        int n;
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `PMCC_ADDR_REF, {31'h0, s[0]});
            apb(1'b1, `PMCC_ADDR_PAD, 32'h1);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (tick !== 1'b1 && n < 200);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (tick !== 1'b1 && n < 200);
            chk(n, s ? `PMCC_DIV_26M : `PMCC_DIV_36M);
        end
        // Divider stays quiet in power-down
        apb(1'b1, `PMCC_ADDR_MODE, 32'h1);
        // Let the stop reach the divider; a last tick may still leave
        w(2);
        n = 0;
        repeat (150) begin
            @(posedge clk_i);
            if (tick !== 1'b0) n++;
        end
        chk(n, 0);
        apb(1'b1, `PMCC_ADDR_MODE, 32'h0);
        $display("test tick done");
    endtask

    task automatic t_port();
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, `PMCC_ADDR_PORT, v);
            w(2);
            chk(pin_o, v[1]);
            chk(pin_oe_n, v[0] & v[1]);
            chk(pin_wire, v[1]);
        end
        apb(1'b1, `PMCC_ADDR_PORT, 32'h2);
        apb(1'b1, `PMCC_ADDR_MODE, 32'h1);
        w(2);
        chk({pin_o, pin_oe_n}, 2'h2);
        apb(1'b1, `PMCC_ADDR_PORT, 32'h1);
        w(2);
        chk({pin_o, pin_oe_n, pin_wire}, 3'h0);
        apb(1'b1, `PMCC_ADDR_MODE, 32'h0);
        w(3);
        chk({pin_o, pin_oe_n, pin_wire}, 3'h0);
        $display("test port done");
    endtask

    //--------------------------------------------------------------------
    // Clock, timeout and main sequence
    //--------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // A hang is cut short well past the expected run length
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            $display("mismatch at %0t: run timed out", $time);
            close_out();
        end
    end

    initial begin
        {psel, penable, pwrite, enable_i, pin_open} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pin_lvl = 2'h0;
        n_errors = 0;
        checks = 0;
        sys_rst_i = 1'b1;
        w(3);
        sys_rst_i <= 1'b0;
        t_reset();
        t_power();
        t_pins();
        t_override();
        t_tick();
        t_port();
        close_out();
    end
endmodule
